// File: hw/ifm_pkg.sv
/*
  Constants, types and register map of the input function mapper.
  Assumes a 200 MHz system clock and an APB master with 32-bit data.
*/
package ifm_pkg;
  localparam int NUM_DIN = 6;
  localparam int NUM_PROG = 5;
  localparam int RUN_DIN = 5;
  localparam int NUM_SRC = 6;
  localparam int NUM_ANA = 4;
  localparam int FREQ2_SRC = 5;
  localparam int SAMPLE_W = 16;
  localparam int LEVEL_W = 12;
  localparam int WIN_W = 8;
  localparam int SUM_W = SAMPLE_W + WIN_W;
  localparam int FUNC_W = 4;
  localparam int TRIP_MS_W = 14;
  localparam int NUM_RELAY = 4;
  localparam logic [LEVEL_W-1:0] FULL_SCALE = 12'hfff;
  localparam logic [SAMPLE_W-1:0] ANA_MAX = 16'h0fff;
  localparam logic [SAMPLE_W-1:0] FREQ_MAX_HZ = 16'h7d00;
  // Time base of the limit timer
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] DIN_CFG_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] SRC_FUNC_OFS = 8'h0c;
  localparam logic [7:0] CAL_CMD_OFS = 8'h10;
  localparam logic [7:0] LIMIT_OFS = 8'h14;
  localparam logic [7:0] TRIP_TIME_OFS = 8'h18;
  localparam logic [7:0] WIN_LO_OFS = 8'h1c;
  localparam logic [7:0] WIN_HI_OFS = 8'h20;
  localparam logic [7:0] CAL_BASE_OFS = 8'h24;
  localparam logic [7:0] LEVEL_BASE_OFS = 8'h3c;
  // Field positions
  localparam int DIN_POL_LSB = 20;
  localparam int DIN_PULL_LOW_LOGIC_BIT = 26;
  localparam int CAL_START_BIT = 4;
  localparam int CAL_CONFIRM_BIT = 5;
  localparam int LIMIT_HI_LSB = 16;
  localparam int CAL_MAX_LSB = 16;
  localparam int ST_ACT_LSB = 3;
  localparam int ST_TRIP_BIT = 9;
  localparam int ST_CAL_REF_BIT = 10;
  localparam int ST_FUNC_REF_BIT = 11;
  localparam int ST_CAL_LSB = 12;
  localparam int LEVEL_HI_LSB = 16;

  typedef enum logic [FUNC_W-1:0] {DF_OFF, DF_SEL_B0, DF_SEL_B1, DF_SEL_B2, DF_LOAD, DF_TRIP, DF_BYPASS,
    DF_LEN_CLR, DF_MEM_CLR} din_func_t;
  typedef enum logic [FUNC_W-1:0] {SF_OFF, SF_POSITION, SF_LINE_SPEED, SF_TENSION, SF_DIAMETER, SF_DANCER,
    SF_SPEED_FB, SF_REVOLUTION, SF_BATCH} src_func_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT_MIN, CAL_WAIT_MAX} cal_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic rerr;
    logic [NUM_PROG-1:0][FUNC_W-1:0] din_func;
    logic [NUM_DIN-1:0] din_open_on;
    logic pull_low_logic;
    logic in_menu;
    logic [NUM_DIN-1:0] act_q;
    logic [2:0] cfg_index;
    logic cfg_load;
    logic load_pend;
    logic len_clr;
    logic mem_clr;
    logic trip;
    logic [NUM_RELAY-1:0] relay_off;
    logic [LEVEL_W-1:0] lim_lo;
    logic [LEVEL_W-1:0] lim_hi;
    logic [TRIP_MS_W-1:0] trip_ms;
    logic [31:0] tick_cnt;
    logic [TRIP_MS_W-1:0] over_ms;
    logic [NUM_SRC-1:0][FUNC_W-1:0] src_func;
    logic [NUM_SRC-1:0][WIN_W-1:0] win;
    logic [NUM_SRC-1:0][WIN_W-1:0] fill;
    logic [NUM_SRC-1:0][WIN_W-1:0] wp;
    logic [NUM_SRC-1:0][SUM_W-1:0] sum;
    logic [NUM_SRC-1:0][SAMPLE_W-1:0] cal_min;
    logic [NUM_SRC-1:0][SAMPLE_W-1:0] cal_max;
    logic [NUM_SRC-1:0][LEVEL_W-1:0] level;
    cal_state_t cal_state;
    logic [2:0] cal_src;
    logic cal_refused;
    logic func_refused;
    logic [LEVEL_W-1:0] line_speed;
    logic [LEVEL_W-1:0] diameter;
    logic diam_from_rev;
    logic rev_pulse;
    logic batch_pulse;
  } state_t;
endpackage

// File: hw/input_function_mapper.sv
/*
  Input conditioning and function assignment for a dancer position controller.
  Assumes APB with zero-wait access phase, samples already digitised per source.
*/
`timescale 1ns/10ps
module input_function_mapper
  import ifm_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  // Register bus
  input wire apb_req_t I_APB,
  output apb_rsp_t O_APB,
  // Field inputs
  input wire logic [NUM_DIN-1:0] I_DIN,
  input wire logic [NUM_SRC-1:0][SAMPLE_W-1:0] I_SAMPLE,
  input wire logic [NUM_SRC-1:0] I_SAMPLE_VALID,
  input wire logic I_FREQ2_PULSE,
  input wire logic [NUM_RELAY-1:0] I_RELAY_TRIP_MASK,
  // Control outputs
  output logic [2:0] O_CFG_INDEX,
  output logic O_CFG_LOAD,
  output logic O_RUN_ENABLE,
  output logic O_CTRL_ZERO,
  output logic [NUM_RELAY-1:0] O_RELAY_OFF,
  output logic O_LEN_CLR,
  output logic O_MEM_CLR,
  // Scaled levels and routed functions
  output logic [NUM_SRC-1:0][LEVEL_W-1:0] O_SRC_LEVEL,
  output logic [LEVEL_W-1:0] O_LINE_SPEED,
  output logic [LEVEL_W-1:0] O_DIAMETER,
  output logic O_DIAM_FROM_REV,
  output logic O_REV_PULSE,
  output logic O_BATCH_PULSE
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic din_has(input logic [NUM_PROG-1:0][FUNC_W-1:0] fn, input din_func_t f);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < NUM_PROG; k++)
    begin
      if (fn[k] == f)
        hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic din_act(input logic [NUM_PROG-1:0][FUNC_W-1:0] fn, input logic [NUM_DIN-1:0] act,
    input din_func_t f);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < NUM_PROG; k++)
    begin
      if (fn[k] == f && act[k])
        hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic [3:0] src_find(input logic [NUM_SRC-1:0][FUNC_W-1:0] fn, input src_func_t f);
    logic [3:0] res;
    res = 4'h0;
    for (int k = NUM_SRC - 1; k >= 0; k--)
    begin
      if (fn[k] == f)
        res = {1'b1, 3'(k)};
    end
    return res;
  endfunction

  function automatic logic [SAMPLE_W-1:0] clamp_level(input int idx, input logic [SAMPLE_W-1:0] v);
    logic [SAMPLE_W-1:0] top;
    top = (idx < NUM_ANA) ? ANA_MAX : FREQ_MAX_HZ;
    return (v > top) ? top : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and sample history

  state_t st;
  state_t next_st;
  logic [SAMPLE_W-1:0] hist [NUM_SRC][256];
  logic [NUM_SRC-1:0][SAMPLE_W-1:0] oldest;
  logic [NUM_SRC-1:0][SAMPLE_W-1:0] smoothing_window;
  logic [NUM_SRC-1:0][LEVEL_W-1:0] scaled;
  logic [NUM_DIN-1:0] din_active;

  // Closed contact level depends on logic type, then polarity
  assign din_active = I_DIN ^ {NUM_DIN{st.pull_low_logic}} ^ st.din_open_on;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_src
      logic [SAMPLE_W-1:0] span;
      logic [SAMPLE_W-1:0] diff;
      logic [SAMPLE_W+LEVEL_W-1:0] prod;

      always_ff @(posedge I_SYS_CLK)
      begin
        if (I_SAMPLE_VALID[g])
          hist[g][st.wp[g]] <= clamp_level(g, I_SAMPLE[g]);
      end

      assign oldest[g] = hist[g][8'(st.wp[g] - st.win[g])];
      assign smoothing_window[g] = (st.fill[g] == '0) ? '0 : SAMPLE_W'(st.sum[g] / st.fill[g]);
      assign span = st.cal_max[g] - st.cal_min[g];
      assign diff = smoothing_window[g] - st.cal_min[g];
      assign prod = diff * FULL_SCALE;

      always_comb
      begin
        if (smoothing_window[g] <= st.cal_min[g])
          scaled[g] = '0;
        else if (smoothing_window[g] >= st.cal_max[g])
          scaled[g] = FULL_SCALE;
        else
          scaled[g] = LEVEL_W'(prod / span);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic wr;
    logic rd;
    logic [31:0] wd;
    logic [NUM_SRC-1:0][WIN_W-1:0] new_win;
    logic [2:0] sel;
    logic load_on;
    logic load_rise;
    logic ext_trip;
    logic bypass;
    logic out_lim;
    logic int_trip;
    logic [3:0] dcr;
    logic [3:0] lsp;
    logic [3:0] dia;
    logic [FUNC_W-1:0] nf;
    logic ok;
    int ci;
    wr = I_APB.psel && I_APB.penable && I_APB.pwrite;
    rd = I_APB.psel && !I_APB.penable;
    wd = I_APB.pwdata;
    nf = '0;
    ok = 1'b0;
    ci = 0;
    new_win = st.win;
    next_st = st;
    next_st.cfg_load = 1'b0;
    next_st.len_clr = 1'b0;
    next_st.mem_clr = 1'b0;
    next_st.act_q = din_active;

    // Selector bits and apply strobe
    sel = {din_act(st.din_func, din_active, DF_SEL_B2), din_act(st.din_func, din_active, DF_SEL_B1),
      din_act(st.din_func, din_active, DF_SEL_B0)};
    load_on = din_act(st.din_func, din_active, DF_LOAD);
    load_rise = load_on && !din_act(st.din_func, st.act_q, DF_LOAD);
    if (st.in_menu)
    begin
      if (load_rise)
        next_st.load_pend = 1'b1;
    end
    else if (din_has(st.din_func, DF_LOAD))
    begin
      if (load_rise || st.load_pend)
      begin
        next_st.cfg_load = 1'b1;
        next_st.cfg_index = sel;
        next_st.load_pend = 1'b0;
      end
    end
    else
    begin
      next_st.load_pend = 1'b0;
      if (sel != st.cfg_index)
      begin
        next_st.cfg_load = 1'b1;
        next_st.cfg_index = sel;
      end
    end

    // Clear strobes on activation
    next_st.len_clr = din_act(st.din_func, din_active, DF_LEN_CLR)
      && !din_act(st.din_func, st.act_q, DF_LEN_CLR);
    next_st.mem_clr = din_act(st.din_func, din_active, DF_MEM_CLR)
      && !din_act(st.din_func, st.act_q, DF_MEM_CLR);

    // Trip handling
    ext_trip = din_act(st.din_func, din_active, DF_TRIP);
    bypass = din_act(st.din_func, din_active, DF_BYPASS);
    dcr = src_find(st.src_func, SF_DANCER);
    out_lim = dcr[3] && (st.level[dcr[2:0]] < st.lim_lo || st.level[dcr[2:0]] > st.lim_hi);
    next_st.tick_cnt = (st.tick_cnt >= 32'(TICK_CYC - 1)) ? '0 : st.tick_cnt + 32'h1;
    if (!out_lim)
      next_st.over_ms = '0;
    else if (st.tick_cnt == '0 && st.over_ms < st.trip_ms)
      next_st.over_ms = st.over_ms + 1'b1;
    int_trip = out_lim && st.over_ms >= st.trip_ms;
    next_st.trip = !bypass && (ext_trip || int_trip || (st.trip && din_active[RUN_DIN]));
    next_st.relay_off = next_st.trip ? I_RELAY_TRIP_MASK : '0;

    // Averaging windows
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (I_SAMPLE_VALID[i])
      begin
        next_st.wp[i] = st.wp[i] + 1'b1;
        if (st.fill[i] < st.win[i])
        begin
          next_st.fill[i] = st.fill[i] + 1'b1;
          next_st.sum[i] = st.sum[i] + SUM_W'(clamp_level(i, I_SAMPLE[i]));
        end
        else
          next_st.sum[i] = st.sum[i] + SUM_W'(clamp_level(i, I_SAMPLE[i])) - SUM_W'(oldest[i]);
      end
      next_st.level[i] = scaled[i];
    end

    // Calibration sequence
    if (din_active[RUN_DIN])
      next_st.cal_state = CAL_IDLE;
    else if (wr && I_APB.paddr == CAL_CMD_OFS && wd[CAL_CONFIRM_BIT] && st.cal_state == CAL_WAIT_MIN)
    begin
      next_st.cal_min[st.cal_src] = smoothing_window[st.cal_src];
      next_st.cal_state = CAL_WAIT_MAX;
    end
    else if (wr && I_APB.paddr == CAL_CMD_OFS && wd[CAL_CONFIRM_BIT] && st.cal_state == CAL_WAIT_MAX)
    begin
      next_st.cal_max[st.cal_src] = smoothing_window[st.cal_src];
      next_st.cal_state = CAL_IDLE;
    end
    if (wr && I_APB.paddr == CAL_CMD_OFS && wd[CAL_START_BIT])
    begin
      ci = int'(wd[2:0]);
      if (din_active[RUN_DIN] || ci >= NUM_SRC || st.src_func[wd[2:0]] == SF_REVOLUTION
        || st.src_func[wd[2:0]] == SF_BATCH)
        next_st.cal_refused = 1'b1;
      else
      begin
        next_st.cal_src = wd[2:0];
        next_st.cal_state = CAL_WAIT_MIN;
      end
    end

    // Register writes
    if (wr)
    begin
      case (I_APB.paddr)
        DIN_CFG_OFS:
        begin
          next_st.din_func = wd[NUM_PROG*FUNC_W-1:0];
          next_st.din_open_on = wd[DIN_POL_LSB +: NUM_DIN];
          next_st.pull_low_logic = wd[DIN_PULL_LOW_LOGIC_BIT];
        end
        CTRL_OFS: next_st.in_menu = wd[0];
        STATUS_OFS:
        begin
          if (wd[ST_CAL_REF_BIT])
            next_st.cal_refused = 1'b0;
          if (wd[ST_FUNC_REF_BIT])
            next_st.func_refused = 1'b0;
        end
        SRC_FUNC_OFS:
        begin
          for (int i = 0; i < NUM_SRC; i++)
          begin
            nf = wd[i*FUNC_W +: FUNC_W];
            ok = nf <= SF_BATCH;
            if (nf == SF_SPEED_FB && i < NUM_ANA)
              ok = 1'b0;
            if ((nf == SF_REVOLUTION || nf == SF_BATCH) && i != FREQ2_SRC)
              ok = 1'b0;
            for (int j = 0; j < NUM_SRC; j++)
            begin
              if (j != i && nf != SF_OFF && next_st.src_func[j] == nf)
                ok = 1'b0;
            end
            if (ok)
              next_st.src_func[i] = nf;
            else if (nf != st.src_func[i])
              next_st.func_refused = 1'b1;
          end
        end
        LIMIT_OFS:
        begin
          next_st.lim_lo = wd[LEVEL_W-1:0];
          next_st.lim_hi = wd[LIMIT_HI_LSB +: LEVEL_W];
        end
        TRIP_TIME_OFS: next_st.trip_ms = wd[TRIP_MS_W-1:0];
        WIN_LO_OFS:
        begin
          for (int i = 0; i < NUM_ANA; i++)
            new_win[i] = wd[i*WIN_W +: WIN_W];
        end
        WIN_HI_OFS:
        begin
          for (int i = NUM_ANA; i < NUM_SRC; i++)
            new_win[i] = wd[(i-NUM_ANA)*WIN_W +: WIN_W];
        end
        default:
        begin
          for (int i = 0; i < NUM_SRC; i++)
          begin
            if (I_APB.paddr == CAL_BASE_OFS + 8'(4*i))
            begin
              if (din_active[RUN_DIN] || st.src_func[i] == SF_REVOLUTION || st.src_func[i] == SF_BATCH)
                next_st.cal_refused = 1'b1;
              else
              begin
                next_st.cal_min[i] = clamp_level(i, wd[SAMPLE_W-1:0]);
                next_st.cal_max[i] = clamp_level(i, wd[CAL_MAX_LSB +: SAMPLE_W]);
              end
            end
          end
        end
      endcase
    end
    // Window change restarts the average
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (new_win[i] == '0)
        new_win[i] = 8'h01;
      if (new_win[i] != st.win[i])
      begin
        next_st.win[i] = new_win[i];
        next_st.fill[i] = '0;
        next_st.sum[i] = '0;
      end
    end

    // Routed functions
    lsp = src_find(st.src_func, SF_LINE_SPEED);
    next_st.line_speed = lsp[3] ? st.level[lsp[2:0]] : FULL_SCALE;
    dia = src_find(st.src_func, SF_DIAMETER);
    next_st.diameter = dia[3] ? st.level[dia[2:0]] : '0;
    next_st.diam_from_rev = !dia[3] && st.src_func[FREQ2_SRC] == SF_REVOLUTION;
    next_st.rev_pulse = I_FREQ2_PULSE && st.src_func[FREQ2_SRC] == SF_REVOLUTION;
    next_st.batch_pulse = I_FREQ2_PULSE && st.src_func[FREQ2_SRC] == SF_BATCH;

    // Read data captured in the setup cycle
    if (rd)
    begin
      next_st.rerr = 1'b0;
      next_st.rdata = '0;
      case (I_APB.paddr)
        DIN_CFG_OFS: next_st.rdata = {5'h00, st.pull_low_logic, st.din_open_on, st.din_func};
        CTRL_OFS: next_st.rdata = {31'h0, st.in_menu};
        STATUS_OFS: next_st.rdata = {18'h0, st.cal_state, st.func_refused, st.cal_refused, st.trip,
          din_active, st.cfg_index};
        SRC_FUNC_OFS: next_st.rdata = {8'h00, st.src_func};
        LIMIT_OFS: next_st.rdata = {4'h0, st.lim_hi, 4'h0, st.lim_lo};
        TRIP_TIME_OFS: next_st.rdata = {18'h0, st.trip_ms};
        WIN_LO_OFS: next_st.rdata = st.win[NUM_ANA-1:0];
        WIN_HI_OFS: next_st.rdata = {16'h0, st.win[NUM_SRC-1:NUM_ANA]};
        default:
        begin
          next_st.rerr = 1'b1;
          for (int i = 0; i < NUM_SRC; i++)
          begin
            if (I_APB.paddr == CAL_BASE_OFS + 8'(4*i))
            begin
              next_st.rerr = 1'b0;
              next_st.rdata = {st.cal_max[i], st.cal_min[i]};
            end
          end
          for (int i = 0; i < NUM_SRC/2; i++)
          begin
            if (I_APB.paddr == LEVEL_BASE_OFS + 8'(4*i))
            begin
              next_st.rerr = 1'b0;
              next_st.rdata = {4'h0, st.level[2*i+1], 4'h0, st.level[2*i]};
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      st <= '0;
      st.win <= {NUM_SRC{8'h01}};
      st.cal_max <= {NUM_ANA{ANA_MAX}} | {{(NUM_SRC-NUM_ANA)*SAMPLE_W{1'b0}}, {NUM_ANA*SAMPLE_W{1'b0}}}
        | {{(NUM_SRC-NUM_ANA){FREQ_MAX_HZ}}, {NUM_ANA*SAMPLE_W{1'b0}}};
      st.lim_hi <= FULL_SCALE;
      st.line_speed <= FULL_SCALE;
      st.cal_state <= CAL_IDLE;
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign O_APB.pready = I_APB.psel && I_APB.penable;
  assign O_APB.pslverr = I_APB.psel && I_APB.penable && st.rerr;
  assign O_APB.prdata = st.rdata;
  assign O_CFG_INDEX = st.cfg_index;
  assign O_CFG_LOAD = st.cfg_load;
  assign O_RUN_ENABLE = st.act_q[RUN_DIN];
  assign O_CTRL_ZERO = st.trip;
  assign O_RELAY_OFF = st.relay_off;
  assign O_LEN_CLR = st.len_clr;
  assign O_MEM_CLR = st.mem_clr;
  assign O_SRC_LEVEL = st.level;
  assign O_LINE_SPEED = st.line_speed;
  assign O_DIAMETER = st.diameter;
  assign O_DIAM_FROM_REV = st.diam_from_rev;
  assign O_REV_PULSE = st.rev_pulse;
  assign O_BATCH_PULSE = st.batch_pulse;

endmodule // input_function_mapper

// File: sim/field_switch_model.sv
/*
  Field switch model: six contacts wired for sourcing or sinking logic.
  Assumes the bench sets each contact state and the wiring kind.
*/
`timescale 1ns/10ps
module field_switch_model
  import ifm_pkg::*;
(
  // Contact state and wiring kind
  input wire logic [NUM_DIN-1:0] i_closed,
  input wire logic i_pull_low_logic,
  // Terminal levels
  output logic [NUM_DIN-1:0] o_din
);
  // Idle low and driven high, or idle high and pulled low
  assign o_din = i_pull_low_logic ? ~i_closed : i_closed;
endmodule // field_switch_model

// File: sim/ifm_chk.sv
/*
  Port checker of the input function mapper.
  Assumes one clock domain; bound to every instance of the top module.
*/
`timescale 1ns/10ps
module ifm_chk
  import ifm_pkg::*;
(
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  // Inputs
  input wire apb_req_t I_APB,
  input wire logic I_FREQ2_PULSE,
  input wire logic [NUM_RELAY-1:0] I_RELAY_TRIP_MASK,
  // Outputs
  input wire apb_rsp_t O_APB,
  input wire logic [2:0] O_CFG_INDEX,
  input wire logic O_CFG_LOAD,
  input wire logic O_CTRL_ZERO,
  input wire logic [NUM_RELAY-1:0] O_RELAY_OFF,
  input wire logic O_LEN_CLR,
  input wire logic O_MEM_CLR,
  input wire logic [LEVEL_W-1:0] O_DIAMETER,
  input wire logic O_DIAM_FROM_REV,
  input wire logic O_REV_PULSE,
  input wire logic O_BATCH_PULSE
);
  ////////////////////////////////////////
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_B);

  a_ready_phase: assert property (O_APB.pready == (I_APB.psel && I_APB.penable))
    else $error("pready not tied to access phase");
  a_err_phase: assert property (O_APB.pslverr |-> I_APB.psel && I_APB.penable)
    else $error("pslverr outside access phase");
  a_index_hold: assert property (!O_CFG_LOAD |-> $stable(O_CFG_INDEX))
    else $error("config index moved without load");
  a_relay_trip: assert property (O_RELAY_OFF == (O_CTRL_ZERO ? $past(I_RELAY_TRIP_MASK) : 4'h0))
    else $error("relay drop differs from trip mask");
  a_diam_excl: assert property (O_DIAM_FROM_REV |-> O_DIAMETER == 12'h000)
    else $error("diameter shown while revolution used");
  a_count_excl: assert property (!(O_REV_PULSE && O_BATCH_PULSE))
    else $error("both counting pulses at once");
  a_count_cause: assert property ((O_REV_PULSE || O_BATCH_PULSE) |-> $past(I_FREQ2_PULSE))
    else $error("counting pulse without input pulse");
  a_len_pulse: assert property (O_LEN_CLR |=> !O_LEN_CLR)
    else $error("length clear longer than one cycle");
  a_mem_pulse: assert property (O_MEM_CLR |-> !$past(O_MEM_CLR))
    else $error("memory clear longer than one cycle");
endmodule // ifm_chk

bind input_function_mapper ifm_chk u_chk (.I_SYS_CLK, .I_RST_B, .I_APB, .I_FREQ2_PULSE,
  .I_RELAY_TRIP_MASK, .O_APB, .O_CFG_INDEX, .O_CFG_LOAD, .O_CTRL_ZERO, .O_RELAY_OFF,
  .O_LEN_CLR, .O_MEM_CLR, .O_DIAMETER, .O_DIAM_FROM_REV, .O_REV_PULSE, .O_BATCH_PULSE);

// File: sim/tb_top.sv
/*
  Bench of the input function mapper: hand tests around the selector and function tables.
  Assumes the field switch model on the inputs and the bound port checker.
*/
`timescale 1ns/10ps
module tb_top
  import ifm_pkg::*;
;
  typedef struct packed {logic [5:0] sw; logic [2:0] idx;} sel_row_t;
  typedef struct packed {logic [31:0] word; logic refused;} fn_row_t;
  localparam logic [19:0] FN_B = {DF_TRIP, DF_BYPASS, DF_MEM_CLR, DF_LEN_CLR, DF_SEL_B0};
  sel_row_t sel_rows [6] = '{'{6'h01, 3'h1}, '{6'h02, 3'h2}, '{6'h04, 3'h4}, '{6'h07, 3'h7},
    '{6'h05, 3'h5}, '{6'h00, 3'h0}};
  // Source function codes, four bits per source
  fn_row_t fn_rows [5] = '{'{32'h0000_0002, 1'b0}, '{32'h0000_0022, 1'b1},
    '{32'h0000_0006, 1'b1}, '{32'h0007_0002, 1'b1}, '{32'h0070_0002, 1'b0}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  apb_req_t apb = '0;
  apb_rsp_t rsp;
  logic [5:0] closed = '0;
  logic sinkm = 1'b0;
  logic [5:0] din;
  logic [NUM_SRC-1:0][SAMPLE_W-1:0] samp = '0;
  logic [NUM_SRC-1:0] vld = '0;
  logic fp = 1'b0;
  logic [3:0] mask = 4'ha;
  logic [2:0] idx;
  logic load, run, zero, lenc, memc, frev, revp, batp;
  logic [3:0] roff;
  logic [11:0] lspd, diam;
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int n_tests = 0;

  input_function_mapper #(.TICK_CYC(10)) dut (
    .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_APB(apb), .O_APB(rsp), .I_DIN(din),
    .I_SAMPLE(samp), .I_SAMPLE_VALID(vld), .I_FREQ2_PULSE(fp), .I_RELAY_TRIP_MASK(mask),
    .O_CFG_INDEX(idx), .O_CFG_LOAD(load), .O_RUN_ENABLE(run), .O_CTRL_ZERO(zero),
    .O_RELAY_OFF(roff), .O_LEN_CLR(lenc), .O_MEM_CLR(memc), .O_SRC_LEVEL(),
    .O_LINE_SPEED(lspd), .O_DIAMETER(diam), .O_DIAM_FROM_REV(frev), .O_REV_PULSE(revp),
    .O_BATCH_PULSE(batp)
  );
  field_switch_model sw_model (.i_closed(closed), .i_pull_low_logic(sinkm), .o_din(din));

  always #2.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (rsp.pready !== 1'b1 && k < 20);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    apb <= '0;
    if (rsp.pready !== 1'b1)
    begin
      fail_count++;
      $display("mismatch at %0t: bus timeout", $time);
      results();
    end
    @(posedge clk);
  endtask

  // Pulse seen within four cycles: 0 load, 1 length, 2 memory, 3 revolution, 4 batch
  task automatic pulse(input int s, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      seen = seen | (s == 0 ? load : s == 1 ? lenc : s == 2 ? memc : s == 3 ? revp : batp);
    end
    chk(seen, exp);
  endtask

  task automatic feed(input int s, input logic [15:0] v);
    samp[s] <= v;
    vld[s] <= 1'b1;
    @(posedge clk);
    vld[s] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(lspd, 12'hfff);
    xfer(1'b0, DIN_CFG_OFS, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b0, 8'h48, 32'h0);
    chk(rerr, 1'b1);
    xfer(1'b0, CAL_CMD_OFS, 32'h0);
    chk(rerr, 1'b1);
    $display("reset test done");
    xfer(1'b1, DIN_CFG_OFS, {12'h0, DF_TRIP, DF_OFF, DF_SEL_B2, DF_SEL_B1, DF_SEL_B0});
    foreach (sel_rows[i])
    begin
      closed <= sel_rows[i].sw;
      pulse(0, 1'b1);
      chk(idx, sel_rows[i].idx);
    end
    $display("selector test done");
    xfer(1'b1, DIN_CFG_OFS, {12'h0, DF_TRIP, DF_LOAD, DF_SEL_B2, DF_SEL_B1, DF_SEL_B0});
    closed <= 6'h03;
    pulse(0, 1'b0);
    closed <= 6'h0b;
    pulse(0, 1'b1);
    chk(idx, 3'h3);
    closed <= 6'h03;
    xfer(1'b1, CTRL_OFS, 32'h1);
    closed <= 6'h0e;
    pulse(0, 1'b0);
    chk(idx, 3'h3);
    xfer(1'b1, CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    chk(idx, 3'h6);
    $display("strobe test done");
    closed <= 6'h10;
    repeat (3) @(posedge clk);
    chk(zero, 1'b1);
    chk(roff, mask);
    xfer(1'b1, DIN_CFG_OFS, {12'h0, FN_B});
    closed <= 6'h18;
    repeat (3) @(posedge clk);
    chk(zero, 1'b0);
    closed <= 6'h10;
    repeat (3) @(posedge clk);
    chk(zero, 1'b1);
    closed <= 6'h00;
    repeat (3) @(posedge clk);
    chk(zero, 1'b0);
    $display("trip test done");
    closed <= 6'h02;
    pulse(1, 1'b1);
    closed <= 6'h06;
    pulse(2, 1'b1);
    closed <= 6'h04;
    pulse(1, 1'b0);
    closed <= 6'h06;
    xfer(1'b1, DIN_CFG_OFS, {6'h0, 6'h02, FN_B});
    pulse(1, 1'b0);
    closed <= 6'h04;
    pulse(1, 1'b1);
    closed <= 6'h06;
    sinkm <= 1'b1;
    xfer(1'b1, DIN_CFG_OFS, {5'h0, 1'b1, 6'h02, FN_B});
    repeat (4) @(posedge clk);
    closed <= 6'h04;
    pulse(1, 1'b1);
    $display("clear test done");
    foreach (fn_rows[i])
    begin
      xfer(1'b1, STATUS_OFS, 32'h0000_0800);
      xfer(1'b1, SRC_FUNC_OFS, fn_rows[i].word);
      xfer(1'b0, STATUS_OFS, 32'h0);
      chk(rdat[ST_FUNC_REF_BIT], fn_rows[i].refused);
    end
    feed(0, 16'h0800);
    chk(lspd, 12'h800);
    feed(0, 16'h0fff);
    chk(lspd, 12'hfff);
    fp <= 1'b1;
    @(posedge clk);
    fp <= 1'b0;
    pulse(3, 1'b1);
    chk(frev, 1'b1);
    xfer(1'b1, SRC_FUNC_OFS, 32'h0070_0042);
    feed(1, 16'h03e8);
    chk(diam, 12'h3e8);
    chk(frev, 1'b0);
    xfer(1'b1, SRC_FUNC_OFS, 32'h0080_0042);
    fp <= 1'b1;
    @(posedge clk);
    fp <= 1'b0;
    pulse(4, 1'b1);
    $display("source test done");
    closed <= 6'h24;
    repeat (3) @(posedge clk);
    chk(run, 1'b1);
    xfer(1'b1, CAL_CMD_OFS, 32'h0000_0012);
    xfer(1'b0, STATUS_OFS, 32'h0);
    chk(rdat[ST_CAL_REF_BIT], 1'b1);
    closed <= 6'h04;
    xfer(1'b1, STATUS_OFS, 32'h0000_0400);
    xfer(1'b1, CAL_CMD_OFS, 32'h0000_0012);
    xfer(1'b0, STATUS_OFS, 32'h0);
    chk(rdat[ST_CAL_REF_BIT], 1'b0);
    chk(rdat[ST_CAL_LSB +: 2], CAL_WAIT_MIN);
    xfer(1'b1, CAL_CMD_OFS, 32'h0000_0020);
    feed(2, 16'h0a00);
    xfer(1'b1, CAL_CMD_OFS, 32'h0000_0020);
    xfer(1'b0, CAL_BASE_OFS + 8'h08, 32'h0);
    chk(rdat, 32'h0a00_0000);
    $display("calibration test done");
    results();
  end
endmodule // tb_top
